// ---- common/ccd_pkg.sv ----
/*
  Shared constants, state type and helper function for the clock channel
  divider block. Assumes an 8-bit register port with a 10-bit address.
*/
package ccd_pkg;

  // Geometry
  localparam int CCD_NUM_CH = 4;
  localparam int CCD_ADDR_W = 10;
  localparam int CCD_DATA_W = 8;
  localparam int CCD_CNT_W = 4;

  // Register offsets, one entry per channel for period, phase and duty
  localparam logic [9:0] CCD_PER_OFF [CCD_NUM_CH] = '{10'h190, 10'h193, 10'h196, 10'h199};
  localparam logic [9:0] CCD_PHS_OFF [CCD_NUM_CH] = '{10'h191, 10'h194, 10'h197, 10'h19a};
  localparam logic [9:0] CCD_DUTY_OFF [CCD_NUM_CH] = '{10'h192, 10'h195, 10'h198, 10'h19b};
  localparam logic [9:0] CCD_SYNC_CTRL_OFF = 10'h19c;
  localparam logic [9:0] CCD_STATUS_OFF = 10'h19d;

  // Field positions
  localparam int CCD_LOW_LSB = 4;
  localparam int CCD_HIGH_LSB = 0;
  localparam int CCD_BYPASS_BIT = 7;
  localparam int CCD_BEGIN_LVL_BIT = 4;
  localparam int CCD_DELAY_LSB = 0;
  localparam int CCD_DUTY_OFF_BIT = 0;
  localparam int CCD_IGN_SYNC_BIT = 1;
  localparam int CCD_SOFT_SYNC_BIT = 0;
  localparam int CCD_STAT_SYNC_BIT = 4;

  // Reset values
  localparam logic [7:0] CCD_PER_RST = 8'h00;
  localparam logic [7:0] CCD_PHS_RST = 8'h00;
  localparam logic [7:0] CCD_DUTY_RST = 8'h00;
  localparam logic [7:0] CCD_SYNC_CTRL_RST = 8'h00;

  // Timing: flops in each pin synchroniser
  localparam int CCD_SYNC_STAGES = 2;
  // Weight of the begin level bit in the delay code
  localparam logic [4:0] CCD_BEGIN_WEIGHT = 5'h10;

  typedef enum logic [1:0] {
    CCD_HOLD = 2'b00,
    CCD_WAIT = 2'b01,
    CCD_HIGH = 2'b11,
    CCD_LOW = 2'b10
  } ccd_state_t;

  // Rising edges to wait before the first output transition
  function automatic logic [CCD_CNT_W-1:0] ccd_wait_cycles(input logic [4:0] code);
    logic [4:0] rest;
    rest = (code >= CCD_BEGIN_WEIGHT) ? (code - CCD_BEGIN_WEIGHT) : code;
    return rest[CCD_CNT_W-1:0];
  endfunction : ccd_wait_cycles

endpackage : ccd_pkg

// ---- src/ccd_sync2.sv ----
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes the pins change slower than the system clock.
*/
`timescale 1ns/1ps
module ccd_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Pins in, levels out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  if (W < 1)
  begin : g_bad_width
    $error("ccd_sync2: W must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_r <= RST_VAL;
      o_q <= RST_VAL;
    end
    else
    begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end

endmodule : ccd_sync2

// ---- src/ccd_edge.sv ----
/*
  Edge finder on a synchronised divider input clock level.
  Assumes the level is already clean and at most half the system rate.
*/
`timescale 1ns/1ps
module ccd_edge (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Synchronised level
  input wire logic i_lvl,
  // One-cycle edge pulses
  output logic o_rise,
  output logic o_fall
);

  logic prev_r;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prev_r <= 1'b0;
    else
      prev_r <= i_lvl;
  end

  assign o_rise = i_lvl & ~prev_r;
  assign o_fall = ~i_lvl & prev_r;

endmodule : ccd_edge

// ---- src/ccd_divider_top.sv ----
/*
  Four clock channel dividers with register port, sync hold and coarse delay.
  Assumes the divider input clock pin runs below a quarter of I_SYS_CLK, and
  that the sync pin and register port follow the documented handshakes.
*/
`timescale 1ns/1ps
module ccd_divider_top #(
  parameter int NUM_CH = ccd_pkg::CCD_NUM_CH,
  parameter int CNT_W = ccd_pkg::CCD_CNT_W
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  // Register port
  input wire logic [ccd_pkg::CCD_ADDR_W-1:0] I_ADDR,
  input wire logic [ccd_pkg::CCD_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [ccd_pkg::CCD_DATA_W-1:0] O_RDATA,
  // Divider input clock and sync pin
  input wire logic I_CLK_IN,
  input wire logic I_SYNC_N,
  // Channel outputs
  output logic [ccd_pkg::CCD_NUM_CH-1:0] O_DIV_CLK,
  output logic O_SYNC_BUSY
);

  import ccd_pkg::*;

  // Offset table and field slices are fixed, so other sizes are refused
  if ((NUM_CH != CCD_NUM_CH) || (CNT_W != CCD_CNT_W))
  begin : g_bad_cfg
    $error("ccd_divider_top: NUM_CH and CNT_W must match the package geometry");
  end

  // Register storage
  logic [7:0] per_r [CCD_NUM_CH];
  logic [7:0] phs_r [CCD_NUM_CH];
  logic [7:0] duty_r [CCD_NUM_CH];
  logic [7:0] sync_ctrl_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic pwr_sync_r;
  logic sync_busy_r;

  // Address decode
  logic [CCD_NUM_CH-1:0] hit_per;
  logic [CCD_NUM_CH-1:0] hit_phs;
  logic [CCD_NUM_CH-1:0] hit_duty;
  logic hit_sync_ctrl;
  logic hit_status;
  logic hit_any;

  // Pin side
  logic clk_in_s;
  logic sync_n_s;
  logic in_rise;
  logic in_fall;
  logic sync_act;

  // Per-channel results
  logic [CCD_NUM_CH-1:0] div_out;
  logic [CCD_NUM_CH-1:0] running;
  logic [7:0] status_word;

  genvar gi;
  generate
    for (gi = 0; gi < CCD_NUM_CH; gi++)
    begin : g_dec
      assign hit_per[gi] = (I_ADDR == CCD_PER_OFF[gi]);
      assign hit_phs[gi] = (I_ADDR == CCD_PHS_OFF[gi]);
      assign hit_duty[gi] = (I_ADDR == CCD_DUTY_OFF[gi]);
    end
  endgenerate

  assign hit_sync_ctrl = (I_ADDR == CCD_SYNC_CTRL_OFF);
  assign hit_status = (I_ADDR == CCD_STATUS_OFF);
  assign hit_any = (|hit_per) | (|hit_phs) | (|hit_duty) | hit_sync_ctrl | hit_status;

  // Register writes; unmapped writes are dropped
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      for (int i = 0; i < CCD_NUM_CH; i++)
      begin
        per_r[i] <= CCD_PER_RST;
        phs_r[i] <= CCD_PHS_RST;
        duty_r[i] <= CCD_DUTY_RST;
      end
      sync_ctrl_r <= CCD_SYNC_CTRL_RST;
    end
    else if (I_WR)
    begin
      for (int i = 0; i < CCD_NUM_CH; i++)
      begin
        if (hit_per[i])
          per_r[i] <= I_WDATA;
        if (hit_phs[i])
          phs_r[i] <= I_WDATA;
        if (hit_duty[i])
          duty_r[i] <= I_WDATA;
      end
      if (hit_sync_ctrl)
        sync_ctrl_r <= I_WDATA;
    end
  end

  // Read mux; unmapped reads return zero
  assign status_word = {3'b000, sync_act, running};

  always_comb
  begin
    rdata_nxt = 8'h00;
    for (int i = 0; i < CCD_NUM_CH; i++)
    begin
      if (hit_per[i])
        rdata_nxt = per_r[i];
      if (hit_phs[i])
        rdata_nxt = phs_r[i];
      if (hit_duty[i])
        rdata_nxt = duty_r[i];
    end
    if (hit_sync_ctrl)
      rdata_nxt = sync_ctrl_r;
    if (hit_status)
      rdata_nxt = status_word;
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      rdata_r <= 8'h00;
    else if (I_RD && hit_any)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 8'h00;
  end

  assign O_RDATA = rdata_r;

  // Pin synchronisers; sync pin idles high
  ccd_sync2 #(
    .W(2),
    .RST_VAL(2'b10)
  ) u_pin_sync (
    .i_clk(I_SYS_CLK),
    .i_reset_n(I_RESET_N),
    .i_d({I_SYNC_N, I_CLK_IN}),
    .o_q({sync_n_s, clk_in_s})
  );

  ccd_edge u_in_edge (
    .i_clk(I_SYS_CLK),
    .i_reset_n(I_RESET_N),
    .i_lvl(clk_in_s),
    .o_rise(in_rise),
    .o_fall(in_fall)
  );

  // One-cycle power-up sync so every channel starts from its preset
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      pwr_sync_r <= 1'b1;
      sync_busy_r <= 1'b1;
    end
    else
    begin
      pwr_sync_r <= 1'b0;
      sync_busy_r <= sync_act;
    end
  end

  assign sync_act = ~sync_n_s | sync_ctrl_r[CCD_SOFT_SYNC_BIT];
  assign O_SYNC_BUSY = sync_busy_r;
  assign O_DIV_CLK = div_out;

  generate
    for (gi = 0; gi < CCD_NUM_CH; gi++)
    begin : g_ch
      // Settings in use; only reloaded while the channel is held
      logic [7:0] act_per_r;
      logic [7:0] act_phs_r;
      logic [7:0] act_duty_r;
      ccd_state_t st_r;
      ccd_state_t st_nxt;
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;
      logic out_r;
      logic out_nxt;
      logic pend_r;
      logic pend_nxt;

      logic hold_req;
      logic [CNT_W-1:0] m_cnt;
      logic [CNT_W-1:0] n_cnt;
      logic act_byp;
      logic act_begin;
      logic half_step;
      logic [4:0] live_code;
      logic [CNT_W-1:0] live_wait;
      logic cnt_zero;

      // Excluded channels only take the power-up sync
      assign hold_req = pwr_sync_r | (sync_act & ~duty_r[gi][CCD_IGN_SYNC_BIT]);
      assign m_cnt = act_per_r[CCD_LOW_LSB +: CNT_W];
      assign n_cnt = act_per_r[CCD_HIGH_LSB +: CNT_W];
      assign act_byp = act_phs_r[CCD_BYPASS_BIT];
      assign act_begin = act_phs_r[CCD_BEGIN_LVL_BIT];
      // Correction only for the odd M=N+1 setting; even M=N is already 50%
      assign half_step = ~act_duty_r[CCD_DUTY_OFF_BIT]
                         & ({1'b0, m_cnt} == ({1'b0, n_cnt} + 5'h01));
      assign live_code = {phs_r[gi][CCD_BEGIN_LVL_BIT],
                          phs_r[gi][CCD_DELAY_LSB +: CNT_W]};
      assign live_wait = ccd_wait_cycles(live_code);
      assign cnt_zero = (cnt_r == '0);

      always_comb
      begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        pend_nxt = pend_r;
        if (hold_req)
        begin
          // Static preset; delay count armed from the new code
          st_nxt = CCD_HOLD;
          out_nxt = phs_r[gi][CCD_BEGIN_LVL_BIT];
          cnt_nxt = live_wait;
          pend_nxt = 1'b0;
        end
        else if (act_byp)
        begin
          // Counter idle; output copies the input level
          st_nxt = CCD_WAIT;
          out_nxt = clk_in_s;
          pend_nxt = 1'b0;
        end
        else
        begin
          case (st_r)
            CCD_HOLD:
            begin
              st_nxt = CCD_WAIT;
            end
            CCD_WAIT:
            begin
              if (in_rise)
              begin
                if (!cnt_zero)
                  cnt_nxt = cnt_r - 1'b1;
                else if (act_begin)
                begin
                  // Begin-high adds a full low period: code-16+M+1
                  st_nxt = CCD_LOW;
                  out_nxt = 1'b0;
                  cnt_nxt = m_cnt;
                end
                else
                begin
                  st_nxt = CCD_HIGH;
                  out_nxt = 1'b1;
                  cnt_nxt = n_cnt;
                end
              end
            end
            CCD_HIGH:
            begin
              if (pend_r && in_fall)
              begin
                st_nxt = CCD_LOW;
                out_nxt = 1'b0;
                cnt_nxt = m_cnt;
                pend_nxt = 1'b0;
              end
              else if (in_rise && !pend_r)
              begin
                if (!cnt_zero)
                  cnt_nxt = cnt_r - 1'b1;
                else if (half_step)
                  pend_nxt = 1'b1;
                else
                begin
                  st_nxt = CCD_LOW;
                  out_nxt = 1'b0;
                  cnt_nxt = m_cnt;
                end
              end
            end
            CCD_LOW:
            begin
              if (in_rise)
              begin
                if (!cnt_zero)
                  cnt_nxt = cnt_r - 1'b1;
                else
                begin
                  st_nxt = CCD_HIGH;
                  out_nxt = 1'b1;
                  cnt_nxt = n_cnt;
                end
              end
            end
            default:
            begin
              st_nxt = CCD_HOLD;
              out_nxt = 1'b0;
            end
          endcase
        end
      end

      // Settings latch during hold so a running period is never cut short
      always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
      begin
        if (!I_RESET_N)
        begin
          act_per_r <= CCD_PER_RST;
          act_phs_r <= CCD_PHS_RST;
          act_duty_r <= CCD_DUTY_RST;
        end
        else if (hold_req)
        begin
          act_per_r <= per_r[gi];
          act_phs_r <= phs_r[gi];
          act_duty_r <= duty_r[gi];
        end
      end

      always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
      begin
        if (!I_RESET_N)
        begin
          st_r <= CCD_HOLD;
          cnt_r <= '0;
          out_r <= 1'b0;
          pend_r <= 1'b0;
        end
        else
        begin
          st_r <= st_nxt;
          cnt_r <= cnt_nxt;
          out_r <= out_nxt;
          pend_r <= pend_nxt;
        end
      end

      assign div_out[gi] = out_r;
      assign running[gi] = (st_r != CCD_HOLD);
    end
  endgenerate

endmodule : ccd_divider_top

// ---- tb/ccd_clk_src.sv ----
/* Free-running divider input clock source.
   Assumes the 40 MHz system clock as time base. */
`timescale 1ns/1ps
module ccd_clk_src #(
  parameter int HI = 3,
  parameter int LO = 5
) (
  // Time base
  input wire logic i_clk,
  // Pin to the divider
  output logic o_clk_in
);
  int cnt = 0;
  // Uneven duty on purpose, each level at least two system cycles
  always @(posedge i_clk)
  begin
    cnt <= (cnt >= HI + LO - 1) ? 0 : cnt + 1;
    o_clk_in <= (cnt < HI);
  end
endmodule : ccd_clk_src

// ---- tb/ccd_divider_assertions.sv ----
/* Port-level assertions for the channel dividers.
   Assumes bus and pin timing of the divider top. */
`timescale 1ns/1ps
module ccd_assert_chk #(
  parameter int NUM_CH = 4,
  parameter int CNT_W = 4
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  // Register port
  input wire logic [ccd_pkg::CCD_ADDR_W-1:0] I_ADDR,
  input wire logic [ccd_pkg::CCD_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [ccd_pkg::CCD_DATA_W-1:0] O_RDATA,
  // Pins
  input wire logic I_CLK_IN,
  input wire logic I_SYNC_N,
  input wire logic [ccd_pkg::CCD_NUM_CH-1:0] O_DIV_CLK,
  input wire logic O_SYNC_BUSY
);
  import ccd_pkg::*;
  logic [CCD_NUM_CH-1:0] ign_r;
  wire pp_addr = (I_ADDR >= 10'h190) && (I_ADDR <= 10'h19a) && ((I_ADDR - 10'h190) % 3 != 2);
  wire mapped = (I_ADDR >= 10'h190) && (I_ADDR <= 10'h19d);
  // Sticky: an excluded channel may keep toggling through a hold
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      ign_r <= '0;
    else
      for (int c = 0; c < CCD_NUM_CH; c++)
        if (I_WR && I_ADDR == CCD_DUTY_OFF[c] && I_WDATA[CCD_IGN_SYNC_BIT])
          ign_r[c] <= 1'b1;
  end
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data not zero outside read answer");
  AST_RD_UNMAPPED: assert property (I_RD && !mapped |=> O_RDATA == 8'h00)
    else $error("unmapped read returned data");
  AST_WR_READBACK: assert property (I_WR && pp_addr ##1 !I_WR ##1
    I_RD && I_ADDR == $past(I_ADDR, 2) |=> O_RDATA == $past(I_WDATA, 3))
    else $error("register read back differs from write");
  AST_SYNC_PIN: assert property (!I_SYNC_N [*4] |-> O_SYNC_BUSY)
    else $error("sync pin low without busy");
  AST_HOLD_STATIC: assert property (O_SYNC_BUSY [*4] |->
    ((O_DIV_CLK ^ $past(O_DIV_CLK)) & ~ign_r) == 4'h0)
    else $error("held output moved during sync");
  AST_OUT_ON_EDGE: assert property ((O_DIV_CLK != $past(O_DIV_CLK)) && !O_SYNC_BUSY
    && !$past(O_SYNC_BUSY) && !$past(O_SYNC_BUSY, 2) |-> $past(I_CLK_IN, 3) != $past(I_CLK_IN, 4))
    else $error("output moved without an input edge");
  AST_RISE_ON_RISE: assert property (((O_DIV_CLK & ~$past(O_DIV_CLK)) != 4'h0)
    && !O_SYNC_BUSY && !$past(O_SYNC_BUSY) && !$past(O_SYNC_BUSY, 2)
    |-> $past(I_CLK_IN, 3) && !$past(I_CLK_IN, 4))
    else $error("output rose without an input rise");
  AST_STATUS_SYNC: assert property ((O_SYNC_BUSY [*3] ##0 (I_RD && I_ADDR == CCD_STATUS_OFF))
    ##1 O_SYNC_BUSY |-> O_RDATA[CCD_STAT_SYNC_BIT])
    else $error("status misses active sync");
endmodule : ccd_assert_chk
bind ccd_divider_top ccd_assert_chk #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) u_ccd_assert_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CLK_IN(I_CLK_IN),
  .I_SYNC_N(I_SYNC_N), .O_DIV_CLK(O_DIV_CLK), .O_SYNC_BUSY(O_SYNC_BUSY)
);

// ---- tb/tb.sv ----
/* Self-checking bench for the channel dividers.
   Assumes the free-running input clock model, 8 system cycles a period. */
`timescale 1ns/1ps
module tb;
  import ccd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [CCD_ADDR_W-1:0] addr = '0;
  logic [CCD_DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sync_n = 1'b1;
  logic clk_in;
  logic busy;
  logic [CCD_DATA_W-1:0] rdata;
  logic [CCD_NUM_CH-1:0] div;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Expected periods in system cycles, input high 3 low 5
  localparam int HI [4] = '{19, 16, 128, 3};
  localparam int LO [4] = '{21, 24, 128, 5};
  localparam logic [7:0] PER [4] = '{8'h21, 8'h21, 8'hff, 8'h00};
  localparam logic [7:0] PHS [4] = '{8'h00, 8'h00, 8'h00, 8'h80};
  localparam int DLY [4] = '{0, 3, 4, 15};
  localparam logic [7:0] DPH [4] = '{8'h00, 8'h03, 8'h12, 8'h0f};

  initial forever #12.5 clk = ~clk;

  ccd_clk_src u_ccd_clk_src (.i_clk(clk), .o_clk_in(clk_in));
  ccd_divider_top u_ccd_divider_top (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CLK_IN(clk_in),
    .I_SYNC_N(sync_n), .O_DIV_CLK(div), .O_SYNC_BUSY(busy)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Idle cycle after each strobe keeps one assignment per signal per step
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
    @(posedge clk);
  endtask : rd_reg

  task automatic wait_lvl(input int c, input logic v, output int n);
    n = 0;
    while (div[c] !== v && n < 600)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_lvl

  task automatic measure(input int c, input int hi, input int lo);
    int n;
    @(negedge clk);
    wait_lvl(c, 1'b0, n);
    wait_lvl(c, 1'b1, n);
    wait_lvl(c, 1'b0, n);
    check(n, hi);
    wait_lvl(c, 1'b1, n);
    check(n, lo);
    @(posedge clk);
  endtask : measure

  initial
  begin
    #1000000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    int n;
    int rt [4];
    logic [3:0] pv;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int c = 0; c < 4; c++)
    begin
      rd_reg(CCD_PER_OFF[c], 8'h00);
      rd_reg(CCD_PHS_OFF[c], 8'h00);
      rd_reg(CCD_DUTY_OFF[c], 8'h00);
      wr_reg(CCD_PER_OFF[c], 8'ha5);
      rd_reg(CCD_PER_OFF[c], 8'ha5);
      wr_reg(CCD_PHS_OFF[c], 8'h9f);
      rd_reg(CCD_PHS_OFF[c], 8'h9f);
    end
    rd_reg(10'h3ff, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(CCD_PER_OFF[c], PER[c]); // Odd split keeps M one above N on channels 0 and 1; 2 and 3 have M equal to N
      wr_reg(CCD_PHS_OFF[c], PHS[c]); // Bypass only on a direct input path
      wr_reg(CCD_DUTY_OFF[c], (c == 1) ? 8'h01 : 8'h00);
    end
    wr_reg(CCD_SYNC_CTRL_OFF, 8'h01);
    repeat (8) @(posedge clk);
    rd_reg(CCD_STATUS_OFF, 8'h10);
    wr_reg(CCD_SYNC_CTRL_OFF, 8'h00);
    repeat (8) @(posedge clk);
    rd_reg(CCD_STATUS_OFF, 8'h0f);
    for (int c = 0; c < 4; c++)
      measure(c, HI[c], LO[c]);
    wr_reg(CCD_PER_OFF[1], 8'h00);
    measure(1, HI[1], LO[1]);
    $display("test division done");
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(CCD_PER_OFF[c], 8'h11); // Even split keeps M equal to N
      wr_reg(CCD_PHS_OFF[c], DPH[c]);
      wr_reg(CCD_DUTY_OFF[c], 8'h00);
    end
    sync_n <= 1'b0;
    repeat (12) @(posedge clk);
    #1 check(div, 4'b0100);
    check(busy, 1'b1);
    @(posedge clk);
    sync_n <= 1'b1;
    pv = div;
    rt = '{-1, -1, -1, -1};
    for (n = 0; n < 400; n++)
    begin
      @(negedge clk);
      for (int c = 0; c < 4; c++)
        if (rt[c] < 0 && div[c] === 1'b1 && pv[c] === 1'b0)
          rt[c] = n;
      pv = div;
    end
    for (int c = 1; c < 4; c++)
      check(rt[c] - rt[0], DLY[c] * 8);
    $display("test delay done");
    // Excluded channel keeps running while the others hold their presets
    @(posedge clk);
    wr_reg(CCD_DUTY_OFF[3], 8'h02);
    sync_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(CCD_STATUS_OFF, 8'h18);
    #1 check(div[2:0], 3'b100);
    @(posedge clk);
    sync_n <= 1'b1;
    $display("test exclusion done");
    end_sim();
  end
endmodule : tb
